// ### core/muldiv_pkg.sv
// package for the multiply-accumulate and divide unit
// assumes a single core clock and the issue logic decoding major opcode on its side too
package muldiv_pkg;
    // ==========================================
    // instruction fields
    localparam logic [5:0] media_major_opcode = 6'h1C;
    localparam logic [5:0] fn_signed_div      = 6'h1A;
    localparam logic [5:0] fn_unsigned_div    = 6'h1B;
    localparam logic [5:0] fn_mul_acc         = 6'h00;
    localparam int         op_pos             = 26;
    localparam int         src_a_pos          = 21;
    localparam int         src_b_pos          = 16;
    localparam int         tgt_pos            = 11;
    // ==========================================
    // timing, reset and operand values
    localparam logic [5:0]   div_steps        = 6'h20;
    localparam logic [127:0] result_reset     = 128'h0;
    localparam logic [31:0]  most_negative    = 32'h80000000;
    localparam logic [31:0]  minus_one        = 32'hFFFFFFFF;

    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [63:0] src_a;
        logic [63:0] src_b;
    } issue_type;

    typedef struct packed {
        logic        valid;
        logic [4:0]  index;
        logic [63:0] data;
    } gpr_write_type;
endpackage

// ### core/muldiv_unit.sv
// multiply-accumulate and 32-bit divide unit with result interlocks
// assumes the issuing pipelines hold a read while its stall output is high
`timescale 1ns/1ns
module muldiv_unit
    import muldiv_pkg::*;
(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          nrst,
    // issue
    input  wire issue_type     issue,
    // reads of result halves
    input  wire logic          rd_upper_req,
    input  wire logic          rd_lower_req,
    output logic               stall_upper_ff,
    output logic               stall_lower_ff,
    // results
    output logic [127:0]       top_word_reg,
    output logic [127:0]       bottom_word_reg,
    output gpr_write_type      gpr_write_ff,
    // no arithmetic exception ever comes out of this unit
    output logic               arith_exc_ff
);
    typedef enum logic [1:0] {
        div_idle = 2'b00,
        div_run  = 2'b01,
        div_fix  = 2'b10
    } div_state_type;

    // ==========================================
    // decode
    wire logic [5:0] opc   = issue.instr[op_pos +: 6];
    wire logic [5:0] fn    = issue.instr[5:0];
    wire logic       media = issue.valid && (opc == media_major_opcode);
    wire logic       is_sdiv = media && (fn == fn_signed_div);
    wire logic       is_udiv = media && (fn == fn_unsigned_div);
    wire logic       is_mac  = media && (fn == fn_mul_acc);
    wire logic [4:0] tgt     = issue.instr[tgt_pos +: 5];

    div_state_type   state_ff;
    logic [5:0]      count_ff;
    logic [31:0]     rem_ff;
    logic [31:0]     quo_ff;
    logic [31:0]     dvs_ff;
    logic            neg_q_ff;
    logic            neg_r_ff;
    logic [127:0]    top_ff;
    logic [127:0]    bottom_ff;
    logic            mac_pend_ff;
    logic [63:0]     prod_ff;
    logic [4:0]      mac_tgt_ff;

    // ==========================================
    // divide: restoring, one bit a cycle on magnitudes
    wire logic [31:0] a_w = issue.src_a[31:0];
    wire logic [31:0] b_w = issue.src_b[31:0];
    // magnitudes; 0x80000000 stays itself, fine as unsigned
    wire logic [31:0] a_mag = (is_sdiv && a_w[31]) ? 32'(-a_w) : a_w;
    wire logic [31:0] b_mag = (is_sdiv && b_w[31]) ? 32'(-b_w) : b_w;
    wire logic [32:0] trial  = {rem_ff, quo_ff[31]} - {1'b0, dvs_ff};
    wire logic        fits   = !trial[32];
    wire logic [31:0] nxt_rem = fits ? trial[31:0] : {rem_ff[30:0], quo_ff[31]};
    wire logic [31:0] nxt_quo = {quo_ff[30:0], fits};
    // sign fixes; wraps so min / -1 yields min and zero remainder
    wire logic [31:0] q_out  = neg_q_ff ? 32'(-quo_ff) : quo_ff;
    wire logic [31:0] r_out  = neg_r_ff ? 32'(-rem_ff) : rem_ff;
    wire logic        div_busy = (state_ff != div_idle);
    wire logic        div_start = (is_sdiv || is_udiv) && !div_busy;

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_ff <= div_idle;
            count_ff <= 6'h00;
            rem_ff   <= 32'h0;
            quo_ff   <= 32'h0;
            dvs_ff   <= 32'h0;
            neg_q_ff <= 1'b0;
            neg_r_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                div_idle:
                    if (div_start)
                    begin
                        state_ff <= div_run;
                        count_ff <= div_steps;
                        rem_ff   <= 32'h0;
                        quo_ff   <= a_mag;
                        dvs_ff   <= b_mag;
                        neg_q_ff <= is_sdiv && (a_w[31] ^ b_w[31]);
                        neg_r_ff <= is_sdiv && a_w[31];
                    end
                div_run:
                begin
                    // zero divisor just runs out its steps
                    rem_ff   <= nxt_rem;
                    quo_ff   <= nxt_quo;
                    count_ff <= count_ff - 6'h01;
                    if (count_ff == 6'h01)
                        state_ff <= div_fix;
                end
                default:
                    state_ff <= div_idle;
            endcase
        end
    end

    // ==========================================
    // multiply-accumulate, product registered then summed next cycle
    // operands widened first so the product keeps all 64 bits
    wire logic signed [63:0] a_sx = {{32{a_w[31]}}, a_w};
    wire logic signed [63:0] b_sx = {{32{b_w[31]}}, b_w};
    wire logic [63:0] mul_w = a_sx * b_sx;
    wire logic [63:0] acc_w = {top_ff[31:0], bottom_ff[31:0]};
    wire logic [63:0] sum_w = acc_w + prod_ff;
    wire logic        mac_start = is_mac && !mac_pend_ff;

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            mac_pend_ff <= 1'b0;
            prod_ff     <= 64'h0;
            mac_tgt_ff  <= 5'h00;
        end
        else
        begin
            mac_pend_ff <= mac_start;
            if (mac_start)
            begin
                prod_ff    <= mul_w;
                mac_tgt_ff <= tgt;
            end
        end
    end

    // ==========================================
    // result registers, halves written independently
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            top_ff       <= result_reset;
            bottom_ff    <= result_reset;
            gpr_write_ff <= '0;
            arith_exc_ff <= 1'b0;
        end
        else
        begin
            arith_exc_ff <= 1'b0;
            gpr_write_ff <= '0;
            if (state_ff == div_fix)
            begin
                bottom_ff[127:64] <= {{32{q_out[31]}}, q_out};
                top_ff[127:64]    <= {{32{r_out[31]}}, r_out};
            end
            if (mac_pend_ff)
            begin
                bottom_ff[63:0] <= {{32{sum_w[31]}}, sum_w[31:0]};
                top_ff[63:0]    <= {{32{sum_w[63]}}, sum_w[63:32]};
                gpr_write_ff.valid <= (mac_tgt_ff != 5'h00);
                gpr_write_ff.index <= mac_tgt_ff;
                gpr_write_ff.data  <= {{32{sum_w[31]}}, sum_w[31:0]};
            end
        end
    end

    assign top_word_reg    = top_ff;
    assign bottom_word_reg = bottom_ff;

    // ==========================================
    // interlocks, one per half so the other half keeps flowing
    wire logic up_busy  = div_start || (div_busy && state_ff != div_fix);
    wire logic low_busy = mac_start;
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            stall_upper_ff <= 1'b0;
            stall_lower_ff <= 1'b0;
        end
        else
        begin
            stall_upper_ff <= rd_upper_req && up_busy;
            stall_lower_ff <= rd_lower_req && low_busy;
        end
    end

    // ==========================================
    // checks
    sequence div_launch_s;
        div_start;
    endsequence
    sequence div_write_s;
        state_ff == div_fix;
    endsequence

    div_latency_a: assert property (@(posedge clock) disable iff (!nrst)
        div_launch_s |-> ##33 div_write_s)
        else $error("divide did not finish in 33 cycles");
    div_overflow_a: assert property (@(posedge clock) disable iff (!nrst)
        (div_start && is_sdiv && a_w == most_negative && b_w == minus_one)
        |-> ##34 (bottom_ff[95:64] == most_negative && top_ff[95:64] == 32'h0))
        else $error("min over minus one wrong");
    no_exc_a: assert property (@(posedge clock) disable iff (!nrst)
        !arith_exc_ff)
        else $error("exception raised");
    div_sign_a: assert property (@(posedge clock) disable iff (!nrst)
        (div_write_s ##0 (neg_r_ff && rem_ff != 32'h0)) |=> top_ff[127])
        else $error("negative remainder lost its sign");
    mac_result_a: assert property (@(posedge clock) disable iff (!nrst)
        mac_start |=> ##1 (bottom_ff[63:0] == gpr_write_ff.data))
        else $error("mac low word mismatch");
    zero_target_a: assert property (@(posedge clock) disable iff (!nrst)
        (mac_start && tgt == 5'h00) |-> ##2 !gpr_write_ff.valid)
        else $error("write to register zero");
    upper_stall_a: assert property (@(posedge clock) disable iff (!nrst)
        (rd_upper_req && div_run == state_ff) |=> stall_upper_ff)
        else $error("upper read not stalled");
    lower_free_a: assert property (@(posedge clock) disable iff (!nrst)
        (rd_lower_req && !mac_start) |=> !stall_lower_ff)
        else $error("lower read stalled by other half");
    upper_keep_a: assert property (@(posedge clock) disable iff (!nrst)
        mac_pend_ff && state_ff != div_fix |=> $stable(top_ff[127:64]))
        else $error("mac touched upper half");
endmodule // muldiv_unit

// ### testbench/reg_file_model.sv
// far-side general register file, fed by the unit's result write port
// assumes writes arrive as one-cycle pulses on the core clock
`timescale 1ns/1ns
module reg_file_model
    import muldiv_pkg::*;
(
    // clock
    input wire logic          clock,
    // result write
    input wire gpr_write_type wr
);
    logic [63:0] regs [32];
    logic [5:0]  wr_count = 6'h00;

    // counts every write so a suppressed one shows as a missing step
    always @(posedge clock)
    begin
        if (wr.valid === 1'b1)
        begin
            regs[wr.index] <= wr.data;
            wr_count       <= wr_count + 6'h01;
        end
    end
endmodule // reg_file_model

// ### testbench/pipe_b_mul_div_accumulate_unit_tb_top.sv
// self-checking bench for the multiply-accumulate and divide unit
// assumes results land 34 edges after a divide and 2 after a multiply-add
`timescale 1ns/1ns
module pipe_b_mul_div_accumulate_unit_tb_top
    import muldiv_pkg::*;
;
    logic          clock = 1'b0;
    logic          nrst  = 1'b0;
    issue_type     issue = '0;
    logic          rd_upper_req = 1'b0;
    logic          rd_lower_req = 1'b0;
    logic          stall_upper_ff;
    logic          stall_lower_ff;
    logic [127:0]  top_word_reg;
    logic [127:0]  bottom_word_reg;
    gpr_write_type gw;
    logic          arith_exc_ff;
    int            num_errors = 0;
    int            num_checks = 0;
    logic [63:0]   acc = 64'h0;

    always #25 clock = ~clock;

    muldiv_unit i_muldiv_unit (.clock(clock), .nrst(nrst), .issue(issue),
        .rd_upper_req(rd_upper_req), .rd_lower_req(rd_lower_req),
        .stall_upper_ff(stall_upper_ff), .stall_lower_ff(stall_lower_ff),
        .top_word_reg(top_word_reg), .bottom_word_reg(bottom_word_reg),
        .gpr_write_ff(gw), .arith_exc_ff(arith_exc_ff));
    reg_file_model i_reg_file_model (.clock(clock), .wr(gw));

    // ==========================================
    // helpers
    function automatic logic [63:0] sx(input logic [31:0] v);
        return {{32{v[31]}}, v};
    endfunction

    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask

    // issue one instruction with reads of both halves beside it, then read once more
    task automatic send(input logic [5:0] fn, input logic [63:0] a, input logic [63:0] b,
                        input logic [4:0] tgt, input logic up_busy, input logic low_busy);
        @(posedge clock);
        issue        <= '{1'b1, {media_major_opcode, 5'h01, 5'h02, tgt, 5'h00, fn}, a, b};
        rd_upper_req <= 1'b1;
        rd_lower_req <= 1'b1;
        @(posedge clock);
        issue.valid <= 1'b0;
        @(negedge clock);
        chk("stall upper at issue", up_busy, stall_upper_ff);
        chk("stall lower at issue", low_busy, stall_lower_ff);
        @(posedge clock);
        rd_upper_req <= 1'b0;
        rd_lower_req <= 1'b0;
        @(negedge clock);
        // a divide still runs here; a multiply-add has just landed, so no lower stall
        chk("stall upper running", up_busy, stall_upper_ff);
        chk("stall lower running", 1'b0, stall_lower_ff);
    endtask

    // ==========================================
    // scenarios
    task automatic div_case(input logic [5:0] fn, input logic [31:0] a, input logic [31:0] b,
                            input logic [31:0] q, input logic [31:0] r, input bit judge);
        logic [63:0] low_keep;
        low_keep = bottom_word_reg[63:0];
        // signed operands sign-extended, unsigned zero-extended
        if (fn == fn_signed_div)
            send(fn, sx(a), sx(b), 5'h00, 1'b1, 1'b0);
        else
            send(fn, {32'h0, a}, {32'h0, b}, 5'h00, 1'b1, 1'b0);
        repeat (34) @(posedge clock);
        @(negedge clock);
        chk("no exception", 1'b0, arith_exc_ff);
        chk("lower kept", low_keep, bottom_word_reg[63:0]);
        if (judge)
        begin
            chk("quotient", sx(q), bottom_word_reg[127:64]);
            chk("remainder", sx(r), top_word_reg[127:64]);
        end
    endtask

    task automatic mac_case(input logic [31:0] a, input logic [31:0] b, input logic [4:0] tgt);
        logic [63:0] up_keep;
        logic [5:0]  n_keep;
        up_keep = top_word_reg[127:64];
        n_keep  = i_reg_file_model.wr_count;
        acc = acc + 64'($signed(a)) * 64'($signed(b));
        send(fn_mul_acc, sx(a), sx(b), tgt, 1'b0, 1'b1);
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("mac low", sx(acc[31:0]), bottom_word_reg[63:0]);
        chk("mac high", sx(acc[63:32]), top_word_reg[63:0]);
        chk("upper kept", up_keep, top_word_reg[127:64]);
        if (tgt == 5'h00)
            chk("gpr suppressed", n_keep, i_reg_file_model.wr_count);
        else
            chk("gpr data", sx(acc[31:0]), i_reg_file_model.regs[tgt]);
    endtask

    // ==========================================
    // closing and watchdog
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #(50 * 6000);
        num_errors++;
        end_sim();
    end

    initial
    begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        chk("top reset", result_reset, top_word_reg);
        chk("bottom reset", result_reset, bottom_word_reg);
        div_case(fn_signed_div, 32'h7, 32'h2, 32'h3, 32'h1, 1);
        div_case(fn_signed_div, 32'hFFFFFFF9, 32'h2, 32'hFFFFFFFD, 32'hFFFFFFFF, 1);
        div_case(fn_signed_div, 32'h7, 32'hFFFFFFFE, 32'hFFFFFFFD, 32'h1, 1);
        div_case(fn_signed_div, 32'hFFFFFFF9, 32'hFFFFFFFE, 32'h3, 32'hFFFFFFFF, 1);
        div_case(fn_signed_div, most_negative, minus_one, most_negative, 32'h0, 1);
        div_case(fn_unsigned_div, 32'hFFFFFFFF, 32'h10, 32'h0FFFFFFF, 32'hF, 1);
        div_case(fn_unsigned_div, 32'hFFFFFFFF, 32'h1, 32'hFFFFFFFF, 32'h0, 1);
        div_case(fn_signed_div, 32'h5, 32'h0, 32'h0, 32'h0, 0);
        div_case(fn_unsigned_div, 32'h64, 32'h7, 32'hE, 32'h2, 1);
        mac_case(32'h7FFFFFFF, 32'h7FFFFFFF, 5'h03);
        mac_case(32'hFFFFFFFD, 32'h00010000, 5'h00);
        mac_case(32'h80000000, 32'h2, 5'h1F);
        end_sim();
    end
endmodule // pipe_b_mul_div_accumulate_unit_tb_top
